// ==== core/bit_manip_defs.vh ====
// Operation codes, operand widths and read-back constants for the bit-manipulation datapath
`ifndef BIT_MANIP_DEFS_VH
`define BIT_MANIP_DEFS_VH

// Operation select codes (4 bits)
`define OP_WIDTH 4
`define BIT_SET_OP 4'h0
`define BIT_CLEAR_OP 4'h1
`define BIT_INVERT_OP 4'h2
`define BIT_TEST_OP 4'h3
`define CARRY_AND_BIT_OP 4'h4
`define CARRY_AND_INVBIT_OP 4'h5
`define CARRY_OR_BIT_OP 4'h6
`define CARRY_OR_INVBIT_OP 4'h7
`define CARRY_XOR_BIT_OP 4'h8
`define CARRY_XOR_INVBIT_OP 4'h9
`define BIT_TO_CARRY_OP 4'ha
`define INVBIT_TO_CARRY_OP 4'hb
`define CARRY_TO_BIT_OP 4'hc
`define INVCARRY_TO_BIT_OP 4'hd

// Operand widths
`define DATA_WIDTH 8
`define ADDR_WIDTH 16
`define BITNO_WIDTH 3

// Value seen when reading a write-only direction register
`define WRITE_ONLY_READ_VALUE 8'hff

// Default address of the write-only port direction register
`define PORT_DIRECTION_ADDR 16'hffb5

`endif

// ==== core/bit_select.v ====
// Bit-number selection and operand bit extraction
`timescale 1ns/1ps
module bit_select
(
    // Bit-number sources
    input wire i_use_reg_bitno,
    input wire [2:0] i_imm_bitno,
    input wire [7:0] i_reg_bitno,
    // Operand and result
    input wire [7:0] i_operand,
    output wire [2:0] o_bitno,
    output wire o_bit
);

    // Register source uses only its low three bits
    assign o_bitno = i_use_reg_bitno ? i_reg_bitno[2:0] : i_imm_bitno;
    assign o_bit = i_operand[o_bitno];

endmodule

// ==== core/bit_modify.v ====
// Single-bit byte modifier: sets one lane of a byte to a given value
`timescale 1ns/1ps
module bit_modify
#(
    parameter WIDTH = 8
)
(
    // Operand and control
    input wire [WIDTH-1:0] i_byte,
    input wire [2:0] i_bitno,
    input wire i_value,
    // Result
    output wire [WIDTH-1:0] o_byte
);

    genvar g;

    // Every other lane passes through untouched
    generate
        for (g = 0; g < WIDTH; g = g + 1)
        begin : lane
            assign o_byte[g] = (i_bitno == g) ? i_value : i_byte[g];
        end
    endgenerate

endmodule

// ==== core/bit_manipulation_unit.v ====
// Bit-manipulation execution unit: register and memory bit operations with carry logic
// Overview of operation
// RULE1 - Set/clear/invert/test take bit number from 3-bit immediate or register low bits.
// RULE2 - Set forces the selected bit to one, other seven unchanged.
// RULE3 - Clear forces the selected bit to zero, others unchanged.
// RULE4 - Invert complements the selected bit, others unchanged.
// RULE5 - Test loads zero flag with complement of selected bit.
// RULE6 - Carry becomes carry AND selected bit.
// RULE7 - Carry becomes carry AND inverted selected bit.
// RULE8 - Carry becomes carry OR selected bit.
// RULE9 - Carry becomes carry OR inverted selected bit.
// RULE10 - Carry becomes carry XOR selected bit.
// RULE11 - Carry becomes carry XOR inverted selected bit.
// RULE12 - Inverted variants take the bit number only from the immediate.
// RULE13 - Bit-load copies selected bit into carry.
// RULE14 - Inverted bit-load copies complement of selected bit into carry.
// RULE15 - Bit-store writes carry into the selected bit.
// RULE16 - Inverted bit-store writes inverted carry into the selected bit.
// RULE17 - Modifying ops read byte, change one bit, write byte to same address.
// RULE18 - Software takes care with write-only bits and port registers.
// RULE19 - Write-only direction register reads as all ones.
// RULE20 - Test, carry-logic and load ops never write their operand.
`timescale 1ns/1ps
`include "bit_manip_defs.vh"
module bit_manipulation_unit
#(
    parameter DATA_WIDTH = `DATA_WIDTH,
    parameter ADDR_WIDTH = `ADDR_WIDTH,
    parameter [ADDR_WIDTH-1:0] PORT_DIRECTION_ADDR = `PORT_DIRECTION_ADDR
)
(
    // Clock and reset
    input wire i_clock,
    input wire i_arst_n,
    // Instruction issue
    input wire i_start,
    input wire [3:0] i_op,
    input wire i_mem_target,
    input wire i_use_reg_bitno,
    input wire [2:0] i_imm_bitno,
    input wire [7:0] i_reg_bitno,
    input wire [DATA_WIDTH-1:0] i_reg_operand,
    input wire [ADDR_WIDTH-1:0] i_mem_addr,
    // Flags in
    input wire i_carry,
    input wire i_zero,
    // Internal bus to memory and peripherals
    input wire [DATA_WIDTH-1:0] i_bus_rdata,
    input wire i_bus_ack,
    output reg [ADDR_WIDTH-1:0] o_bus_addr,
    output reg [DATA_WIDTH-1:0] o_bus_wdata,
    output reg o_bus_read,
    output reg o_bus_write,
    // Results
    output reg o_busy,
    output reg o_done,
    output reg o_illegal,
    output reg [DATA_WIDTH-1:0] o_reg_result,
    output reg o_reg_write,
    output reg o_carry,
    output reg o_carry_write,
    output reg o_zero,
    output reg o_zero_write
);

    ////////////////////////////////////////////////////////////////////////////
    // Sequence summary
    // Register target: issue, modify, done; three edges from issue to done
    // Memory target: issue, read until ack, modify, write until ack, done
    // Flags update in the modify cycle, ahead of any memory write
    // Test, carry-logic and load ops skip the write phase entirely
    // A new issue is accepted in the cycle in which done is high
    // Bit number comes from the immediate or the low register bits
    // Read data from the direction register is forced to all ones
    // Limitation: the whole byte read is written back, so bits that read
    // back differently from what is stored are silently rewritten

    ////////////////////////////////////////////////////////////////////////////
    // States, one-hot
    localparam [4:0] ST_IDLE = 5'h01;
    localparam [4:0] ST_READ = 5'h02;
    localparam [4:0] ST_MODIFY = 5'h04;
    localparam [4:0] ST_WRITE = 5'h08;
    localparam [4:0] ST_DONE = 5'h10;

    // Operation class decode, used for the next-state choice and for the write-back decision
    function is_modify_op;
        input [3:0] op;
        begin
            is_modify_op = (op == `BIT_SET_OP) || (op == `BIT_CLEAR_OP) || (op == `BIT_INVERT_OP)
                || (op == `CARRY_TO_BIT_OP) || (op == `INVCARRY_TO_BIT_OP);
        end
    endfunction

    // Complemented-bit and complemented-carry variants, immediate bit number only
    function is_inverted_op;
        input [3:0] op;
        begin
            is_inverted_op = (op == `CARRY_AND_INVBIT_OP) || (op == `CARRY_OR_INVBIT_OP)
                || (op == `CARRY_XOR_INVBIT_OP) || (op == `INVBIT_TO_CARRY_OP)
                || (op == `INVCARRY_TO_BIT_OP);
        end
    endfunction

    // Codes above the last store variant are unused and refused
    function is_known_op;
        input [3:0] op;
        begin
            is_known_op = (op <= `INVCARRY_TO_BIT_OP);
        end
    endfunction

    ////////////////////////////////////////////////////////////////////////////
    // Latched instruction
    reg [4:0] state_reg;
    reg [4:0] state_next;
    reg [3:0] op_reg;
    reg mem_reg;
    reg use_reg_bitno_reg;
    reg [2:0] imm_bitno_reg;
    reg [7:0] reg_bitno_reg;
    reg [DATA_WIDTH-1:0] operand_reg;
    reg [ADDR_WIDTH-1:0] addr_reg;
    reg carry_in_reg;

    // Bit selection and single-bit modify datapath
    wire [2:0] bitno;
    wire sel_bit;
    reg new_bit;
    wire [DATA_WIDTH-1:0] modified;
    reg carry_new;
    reg carry_upd;

    // Issue qualification
    wire start_ok;
    wire bad_src;

    // Inverted variants cannot take a register bit number [RULE12]
    assign bad_src = is_inverted_op(i_op) && i_use_reg_bitno;
    assign start_ok = i_start && is_known_op(i_op) && !bad_src;

    // Bit-number choice [RULE1]
    bit_select u_bit_select
    (
        .i_use_reg_bitno(use_reg_bitno_reg),
        .i_imm_bitno(imm_bitno_reg),
        .i_reg_bitno(reg_bitno_reg),
        .i_operand(operand_reg),
        .o_bitno(bitno),
        .o_bit(sel_bit)
    );

    // New value of the chosen bit for modifying operations
    always @*
    begin
        case (op_reg)
            `BIT_SET_OP: new_bit = 1'b1; // [RULE2]
            `BIT_CLEAR_OP: new_bit = 1'b0; // [RULE3]
            `BIT_INVERT_OP: new_bit = ~sel_bit; // [RULE4]
            `CARRY_TO_BIT_OP: new_bit = carry_in_reg; // [RULE15]
            `INVCARRY_TO_BIT_OP: new_bit = ~carry_in_reg; // [RULE16]
            // Read-only ops rewrite nothing, so the bit is kept
            default: new_bit = sel_bit;
        endcase
    end

    // Only the chosen lane changes
    bit_modify #(.WIDTH(DATA_WIDTH)) u_bit_modify
    (
        .i_byte(operand_reg),
        .i_bitno(bitno),
        .i_value(new_bit),
        .o_byte(modified)
    );

    // Carry logic
    always @*
    begin
        carry_upd = 1'b1;
        case (op_reg)
            `CARRY_AND_BIT_OP: carry_new = carry_in_reg & sel_bit; // [RULE6]
            `CARRY_AND_INVBIT_OP: carry_new = carry_in_reg & ~sel_bit; // [RULE7]
            `CARRY_OR_BIT_OP: carry_new = carry_in_reg | sel_bit; // [RULE8]
            `CARRY_OR_INVBIT_OP: carry_new = carry_in_reg | ~sel_bit; // [RULE9]
            `CARRY_XOR_BIT_OP: carry_new = carry_in_reg ^ sel_bit; // [RULE10]
            `CARRY_XOR_INVBIT_OP: carry_new = carry_in_reg ^ ~sel_bit; // [RULE11]
            `BIT_TO_CARRY_OP: carry_new = sel_bit; // [RULE13]
            `INVBIT_TO_CARRY_OP: carry_new = ~sel_bit; // [RULE14]
            // Modify and test ops leave the carry alone
            default:
            begin
                carry_new = carry_in_reg;
                carry_upd = 1'b0;
            end
        endcase
    end

    ////////////////////////////////////////////////////////////////////////////
    // Sequencer next state
    always @*
    begin
        state_next = state_reg;
        case (state_reg)
            // Memory targets fetch the byte first
            ST_IDLE:
                if (start_ok)
                    state_next = i_mem_target ? ST_READ : ST_MODIFY;
            // Read strobe stands until the bus answers
            ST_READ:
                if (i_bus_ack)
                    state_next = ST_MODIFY;
            ST_MODIFY:
                // Read-only ops end here without a bus write [RULE20]
                state_next = (mem_reg && is_modify_op(op_reg)) ? ST_WRITE : ST_DONE; // [RULE17]
            // Write-back completes on the bus answer
            ST_WRITE:
                if (i_bus_ack)
                    state_next = ST_DONE;
            // One cycle of done, then ready for the next issue
            ST_DONE:
                state_next = ST_IDLE;
            // Stray codes recover to idle rather than lock up
            default:
                state_next = ST_IDLE;
        endcase
    end

    // Sequencer and datapath registers
    always @(posedge i_clock or negedge i_arst_n)
    begin
        if (!i_arst_n)
        begin
            // Sequencer and latched operands
            state_reg <= ST_IDLE;
            op_reg <= 4'h0;
            mem_reg <= 1'b0;
            use_reg_bitno_reg <= 1'b0;
            imm_bitno_reg <= 3'h0;
            reg_bitno_reg <= 8'h00;
            operand_reg <= {DATA_WIDTH{1'b0}};
            addr_reg <= {ADDR_WIDTH{1'b0}};
            carry_in_reg <= 1'b0;
            // Every output starts low
            o_bus_addr <= {ADDR_WIDTH{1'b0}};
            o_bus_wdata <= {DATA_WIDTH{1'b0}};
            o_bus_read <= 1'b0;
            o_bus_write <= 1'b0;
            o_busy <= 1'b0;
            o_done <= 1'b0;
            o_illegal <= 1'b0;
            o_reg_result <= {DATA_WIDTH{1'b0}};
            o_reg_write <= 1'b0;
            o_carry <= 1'b0;
            o_carry_write <= 1'b0;
            o_zero <= 1'b0;
            o_zero_write <= 1'b0;
        end
        else
        begin
            state_reg <= state_next;
            // Done, result, flag and illegal strobes default low, so each stands a single cycle
            o_done <= 1'b0;
            o_reg_write <= 1'b0;
            o_carry_write <= 1'b0;
            o_zero_write <= 1'b0;
            o_illegal <= 1'b0;
            case (state_reg)
                // Latch the instruction; a refused issue only raises the illegal pulse
                ST_IDLE:
                begin
                    o_illegal <= i_start && !start_ok; // [RULE12]
                    if (start_ok)
                    begin
                        op_reg <= i_op;
                        mem_reg <= i_mem_target;
                        use_reg_bitno_reg <= i_use_reg_bitno;
                        imm_bitno_reg <= i_imm_bitno;
                        reg_bitno_reg <= i_reg_bitno;
                        operand_reg <= i_reg_operand;
                        addr_reg <= i_mem_addr;
                        carry_in_reg <= i_carry;
                        o_zero <= i_zero;
                        o_carry <= i_carry;
                        o_busy <= 1'b1;
                        o_bus_addr <= i_mem_addr;
                        o_bus_read <= i_mem_target; // [RULE17]
                    end
                end
                // Take the read data in the cycle the answer stands
                ST_READ:
                    if (i_bus_ack)
                    begin
                        o_bus_read <= 1'b0;
                        // Write-only direction register reads back as ones [RULE19]
                        if (addr_reg == PORT_DIRECTION_ADDR)
                            operand_reg <= `WRITE_ONLY_READ_VALUE;
                        else
                            operand_reg <= i_bus_rdata;
                    end
                // Flags and results all leave in this one cycle
                ST_MODIFY:
                begin
                    // Only the test op touches the zero flag
                    if (op_reg == `BIT_TEST_OP)
                    begin
                        o_zero <= ~sel_bit; // [RULE5]
                        o_zero_write <= 1'b1;
                    end
                    // Carry-logic and load ops replace the carry
                    if (carry_upd)
                    begin
                        o_carry <= carry_new;
                        o_carry_write <= 1'b1;
                    end
                    // Memory targets go back out on the bus; registers return the byte
                    if (mem_reg && is_modify_op(op_reg))
                    begin
                        o_bus_wdata <= modified; // [RULE17]
                        o_bus_write <= 1'b1;
                    end
                    else if (!mem_reg && is_modify_op(op_reg))
                    begin
                        o_reg_result <= modified;
                        o_reg_write <= 1'b1;
                    end
                end
                // Write strobe drops on the answer
                ST_WRITE:
                    if (i_bus_ack)
                        o_bus_write <= 1'b0;
                // Release busy together with the done pulse
                ST_DONE:
                begin
                    o_busy <= 1'b0;
                    o_done <= 1'b1;
                end
                // Unreachable codes clear busy
                default:
                    o_busy <= 1'b0;
            endcase
        end
    end

endmodule

// ==== verification/bit_manipulation_unit_properties.sv ====
// Concurrent checks on the bit-manipulation unit ports
`timescale 1ns/1ps
module bit_manipulation_unit_properties
#(
    parameter DATA_WIDTH = 8,
    parameter ADDR_WIDTH = 16,
    parameter [ADDR_WIDTH-1:0] PORT_DIRECTION_ADDR = 16'hffb5
)
(
    // Clock, reset, issue and bus answer
    input logic i_clock, i_arst_n, i_start, i_mem_target, i_use_reg_bitno, i_carry, i_bus_ack,
    input logic [3:0] i_op,
    input logic [2:0] i_imm_bitno,
    input logic [7:0] i_reg_bitno,
    input logic [DATA_WIDTH-1:0] i_reg_operand, i_bus_rdata,
    // Bus and results
    input logic o_bus_read, o_bus_write, o_busy, o_done, o_illegal, o_reg_write,
    input logic o_carry, o_carry_write, o_zero, o_zero_write,
    input logic [ADDR_WIDTH-1:0] o_bus_addr,
    input logic [DATA_WIDTH-1:0] o_bus_wdata, o_reg_result
);
    logic [3:0] op_reg;
    logic [2:0] bit_reg;
    logic [7:0] opnd_reg, rd_reg;
    logic mem_reg, c_reg;
    logic [ADDR_WIDTH-1:0] rd_addr_reg;
    wire legal = (i_op <= 4'hd) && !(i_use_reg_bitno && i_op[0] && i_op >= 4'h5);
    wire taken = i_start && !o_busy && legal;
    // Latch the issued op; read data seen as the unit must see it
    always @(posedge i_clock or negedge i_arst_n)
    begin
        if (!i_arst_n)
        begin
            {op_reg, bit_reg, opnd_reg, rd_reg, mem_reg, c_reg} <= '0;
            rd_addr_reg <= '0;
        end
        else
        begin
            if (taken)
            begin
                {op_reg, opnd_reg, mem_reg, c_reg} <= {i_op, i_reg_operand, i_mem_target, i_carry};
                bit_reg <= i_use_reg_bitno ? i_reg_bitno[2:0] : i_imm_bitno;
            end
            if (o_bus_read && i_bus_ack)
            begin
                rd_reg <= (o_bus_addr == PORT_DIRECTION_ADDR) ? 8'hff : i_bus_rdata;
                rd_addr_reg <= o_bus_addr;
            end
        end
    end
    // Expected byte and flags, odd codes invert the operand bit
    wire [7:0] src = mem_reg ? rd_reg : opnd_reg;
    wire [7:0] msk = 8'h01 << bit_reg;
    wire sb = src[bit_reg];
    wire sbx = op_reg[0] ? ~sb : sb;
    wire nb = (op_reg == 4'h0) | ((op_reg == 4'h2) & ~sb) | ((op_reg == 4'hc) & c_reg) | ((op_reg == 4'hd) & ~c_reg);
    wire [7:0] exp_byte = nb ? (src | msk) : (src & ~msk);
    wire exp_c = (op_reg < 4'h6) ? (c_reg & sbx) : (op_reg < 4'h8) ? (c_reg | sbx) : (op_reg < 4'ha) ? (c_reg ^ sbx) : sbx;
    default clocking @(posedge i_clock); endclocking
    default disable iff (!i_arst_n);
    AST_REG_TIMING: assert property (taken && !i_mem_target |-> ##2 (o_reg_write || o_carry_write || o_zero_write)
        ##1 o_done) else $error("register op timing");
    AST_REG_VALUE: assert property (o_reg_write |-> o_reg_result == exp_byte)
        else $error("register result");
    AST_MEM_WDATA: assert property (o_bus_write |-> o_bus_wdata == exp_byte) else $error("write data");
    AST_CARRY_VALUE: assert property (o_carry_write |-> o_carry == exp_c)
        else $error("carry value");
    AST_ZERO_VALUE: assert property (o_zero_write |-> o_zero == !sb) else $error("zero value");
    AST_WRITE_AFTER_READ: assert property ($rose(o_bus_write) |-> $past(o_bus_read, 2) && !o_bus_read)
        else $error("write without read");
    AST_SAME_ADDR: assert property (o_bus_write |-> o_bus_addr == rd_addr_reg) else $error("write address");
    AST_READONLY_NO_WRITE: assert property (o_bus_write |-> op_reg inside {4'h0, 4'h1, 4'h2, 4'hc, 4'hd})
        else $error("read-only op wrote");
    AST_ILLEGAL: assert property (i_start && !o_busy && !legal |=> o_illegal && !o_busy)
        else $error("refusal");
    // Main scenarios reached
    cover property (taken && i_mem_target && i_op == 4'h1);
    cover property (o_illegal);
    cover property (o_bus_write && o_bus_addr == PORT_DIRECTION_ADDR);
endmodule
bind bit_manipulation_unit bit_manipulation_unit_properties #(.DATA_WIDTH(DATA_WIDTH), .ADDR_WIDTH(ADDR_WIDTH),
    .PORT_DIRECTION_ADDR(PORT_DIRECTION_ADDR)) u_props (.i_clock, .i_arst_n, .i_start, .i_mem_target,
    .i_use_reg_bitno, .i_carry, .i_bus_ack, .i_op, .i_imm_bitno, .i_reg_bitno, .i_reg_operand, .i_bus_rdata,
    .o_bus_read, .o_bus_write, .o_busy, .o_done, .o_illegal, .o_reg_write, .o_carry, .o_carry_write, .o_zero,
    .o_zero_write, .o_bus_addr, .o_bus_wdata, .o_reg_result);

// ==== verification/mem_model.sv ====
// Byte store on the internal bus with adjustable answer delay
`timescale 1ns/1ps
module mem_model
(
    // Clock, reset and bus from the unit
    input logic i_clock, i_arst_n, i_read, i_write,
    input logic [15:0] i_addr,
    input logic [7:0] i_wdata,
    input logic [3:0] i_delay,
    // Answer
    output logic [7:0] o_rdata,
    output logic o_ack
);
    logic [7:0] mem [0:255];
    logic [3:0] wait_cnt;
    int wcount = 0;
    // One ack per access; data lines scramble outside the ack cycle
    always @(posedge i_clock or negedge i_arst_n)
    begin
        if (!i_arst_n)
        begin
            o_ack <= 1'b0;
            wait_cnt <= 4'h0;
            o_rdata <= 8'h5a;
        end
        else if (o_ack || !(i_read || i_write))
        begin
            o_ack <= 1'b0;
            wait_cnt <= 4'h0;
            o_rdata <= ~o_rdata;
        end
        else if (wait_cnt != i_delay)
        begin
            wait_cnt <= wait_cnt + 4'h1;
            o_rdata <= ~o_rdata;
        end
        else
        begin
            // True contents, write-only bits too; masking is the unit's job
            o_ack <= 1'b1;
            o_rdata <= mem[i_addr[7:0]];
            if (i_write) mem[i_addr[7:0]] <= i_wdata; // Whole byte taken blindly
            if (i_write) wcount <= wcount + 1;
        end
    end
endmodule

// ==== verification/bit_manipulation_unit_bench.sv ====
// Self-checking bench for the bit-manipulation unit
`timescale 1ns/1ps
module bit_manipulation_unit_bench;
    logic i_clock = 0, i_arst_n = 0, i_start = 0, i_mem_target = 0, i_use_reg_bitno = 0, i_carry = 0, i_zero = 0;
    logic [3:0] i_op = '0, mem_delay = '0;
    logic [2:0] i_imm_bitno = '0;
    logic [7:0] i_reg_bitno = '0, i_reg_operand = '0, i_bus_rdata, o_bus_wdata, o_reg_result, seen_byte;
    logic [15:0] i_mem_addr = '0, o_bus_addr;
    logic i_bus_ack, o_bus_read, o_bus_write, o_busy, o_done, o_illegal, o_reg_write, o_carry, o_carry_write;
    logic o_zero, o_zero_write, seen_c, seen_z, got_done, got_ill;
    int err_count = 0, comparisons = 0;
    bit_manipulation_unit u_dut (.i_clock, .i_arst_n, .i_start, .i_op, .i_mem_target, .i_use_reg_bitno,
        .i_imm_bitno, .i_reg_bitno, .i_reg_operand, .i_mem_addr, .i_carry, .i_zero, .i_bus_rdata, .i_bus_ack,
        .o_bus_addr, .o_bus_wdata, .o_bus_read, .o_bus_write, .o_busy, .o_done, .o_illegal, .o_reg_result,
        .o_reg_write, .o_carry, .o_carry_write, .o_zero, .o_zero_write);
    mem_model u_mem (.i_clock, .i_arst_n, .i_addr(o_bus_addr), .i_read(o_bus_read), .i_write(o_bus_write),
        .i_wdata(o_bus_wdata), .i_delay(mem_delay), .o_rdata(i_bus_rdata), .o_ack(i_bus_ack));
    always #50 i_clock = ~i_clock;
    // Strobes last one cycle, so keep what they carried
    always @(posedge i_clock)
    begin
        if (o_reg_write) seen_byte <= o_reg_result;
        if (o_carry_write) seen_c <= o_carry;
        if (o_zero_write) seen_z <= o_zero;
        if (o_done) got_done <= 1'b1;
        if (o_illegal) got_ill <= 1'b1;
    end
    task check(input string name, input logic [7:0] seen, input logic [7:0] exp);
        comparisons++;
        if (seen !== exp)
        begin
            err_count++;
            $display("MISMATCH %s expected %h seen %h", name, exp, seen);
        end
    endtask
    // Returns {carry, zero, byte}
    function automatic [9:0] expect_op(input logic [3:0] op, input logic [7:0] v, input logic [2:0] b, input logic c);
        logic sb;
        logic sbx;
        logic nb;
        sb = v[b];
        sbx = op[0] ? ~sb : sb;
        nb = (op == 4'h0) | ((op == 4'h2) & ~sb) | ((op == 4'hc) & c) | ((op == 4'hd) & ~c);
        return {(op < 4'h6) ? (c & sbx) : (op < 4'h8) ? (c | sbx) : (op < 4'ha) ? (c ^ sbx) : sbx, ~sb,
            nb ? (v | (8'h01 << b)) : (v & ~(8'h01 << b))};
    endfunction
    // Issue one op; the unused bit-number source carries a decoy
    task run_op(input logic [3:0] op, input logic mem, ureg, input logic [2:0] b, input logic [7:0] v, input logic c,
        input logic [15:0] a);
        int n;
        @(negedge i_clock);
        if (mem) u_mem.mem[a[7:0]] = v;
        {seen_byte, seen_c, seen_z, got_done, got_ill} = {8'hxx, 2'bxx, 2'b00};
        {i_op, i_mem_target, i_use_reg_bitno, i_mem_addr, i_carry, i_start} = {op, mem, ureg, a, c, 1'b1};
        i_imm_bitno = ureg ? ~b : b;
        i_reg_bitno = ureg ? {5'h15, b} : {5'h00, ~b};
        i_reg_operand = mem ? ~v : v;
        @(negedge i_clock);
        i_start = 0;
        for (n = 0; n < 40 && got_done !== 1'b1; n++) @(negedge i_clock);
    endtask
    task test_reg_ops;
        logic [9:0] e;
        logic [3:0] op;
        for (int k = 0; k < 28; k++)
        begin
            op = k[4:1];
            e = expect_op(op, k[0] ? 8'h5a : 8'ha5, k[0] ? 3'h7 : 3'h0, k[0] ^ op[1]);
            run_op(op, 0, k[0] & (op < 5 | ~op[0]), k[0] ? 3'h7 : 3'h0, k[0] ? 8'h5a : 8'ha5, k[0] ^ op[1], '0);
            check("done", got_done, 1);
            if (op < 3 || op > 11) check("byte", seen_byte, e[7:0]);
            else if (op == 3) check("zero", seen_z, e[8]);
            else check("carry", seen_c, e[9]);
        end
    endtask
    task test_mem_ops;
        logic [9:0] e;
        logic [3:0] ops [6];
        int w;
        ops = '{4'h0, 4'h2, 4'hc, 4'hd, 4'h3, 4'ha};
        for (int k = 0; k < 6; k++)
        begin
            mem_delay = k[0] ? 4'h4 : 4'h0;
            w = u_mem.wcount;
            e = expect_op(ops[k], 8'h96, k[2:0] + 3'h1, k[1]);
            run_op(ops[k], 1, 0, k[2:0] + 3'h1, 8'h96, k[1], {13'h0002, k[2:0]});
            if (k < 4) check("mem", u_mem.mem[{5'h02, k[2:0]}], e[7:0]);
            check("writes", u_mem.wcount[7:0] - w[7:0], k < 4 ? 8'h01 : 8'h00);
            if (k == 4) check("zero", seen_z, e[8]);
            if (k == 5) check("carry", seen_c, e[9]);
        end
    endtask
    task test_port_dir;
        run_op(4'h1, 1, 0, 3'h0, 8'h3f, 0, 16'hffb5);
        check("port", u_mem.mem[8'hb5], 8'hfe);
    endtask
    task test_illegal;
        for (int j = 0; j < 6; j++)
        begin
            run_op(j < 5 ? 4'h5 + 2 * j[3:0] : 4'he, 0, 1, 3'h2, 8'h0f, 1, '0);
            check("refused", {got_ill, got_done}, 8'h02);
        end
    endtask
    task finish_test;
        $display("mismatches %0d comparisons %0d", err_count, comparisons);
        if (err_count == 0 && comparisons > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask
    initial
    begin
        repeat (12) @(posedge i_clock);
        @(negedge i_clock);
        i_arst_n = 1;
        test_reg_ops;
        test_mem_ops;
        test_port_dir;
        test_illegal;
        finish_test;
    end
    // Watchdog: the full run needs under a thousand cycles
    initial
    begin
        repeat (5000) @(posedge i_clock);
        err_count++;
        finish_test;
    end
endmodule
